// File: hw/tsf_pkg.sv
// Purpose: Shared constants for the terminal status flags block.
// Assumes: 16-bit status word, 125 MHz system clock.
// Notes:   Bit positions follow the master status and reset word.
package tsf_pkg;

  // ---------------------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------------------
  localparam int unsigned REG_W = 16; // Width of the status word.
  localparam int unsigned BIT_READY = 15; // Host access ready.
  localparam int unsigned BIT_AUTO_INIT_ENABLE_PIN = 13; // Captured auto-init strap.
  localparam int unsigned BIT_MON_RST = 12; // Monitor soft reset request.
  localparam int unsigned BIT_TERM_RST = 10; // Terminal soft reset request.
  localparam int unsigned BIT_MON_MSG = 7; // Monitor message in progress.
  localparam int unsigned BIT_MON_PKT = 6; // Monitor packet in progress.
  localparam int unsigned BIT_TERM_MSG = 4; // Terminal message in progress.
  localparam int unsigned BIT_TERM_INH = 2; // Terminal bus inhibited.
  localparam int unsigned BIT_CKSUM = 1; // EEPROM checksum error.
  localparam int unsigned BIT_RAM_INIT_FAIL = 0; // RAM init mismatch.

  // ---------------------------------------------------------------------------
  // Hardware pending interrupt bits fed by the error flags
  // ---------------------------------------------------------------------------
  localparam int unsigned HWP_CKSUM = 14; // Pending bit for checksum error.
  localparam int unsigned HWP_RAM_INIT_FAIL = 13; // Pending bit for RAM mismatch.

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [15:0] STATUS_RST = 16'h0000; // Every flag low after reset.
  localparam int unsigned CLK_PERIOD_PS = 8000; // 125 MHz clock period.
  localparam int unsigned SOFT_RST_NS = 1000; // Least soft reset duration.
  localparam int unsigned SOFT_RST_CYC =
    (SOFT_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS; // Rounded up.
  localparam int unsigned CNT_W = 8; // Width of the soft reset counter.

  // Soft reset sequencer states.
  typedef enum logic [0:0] {SR_IDLE, SR_BUSY} tsf_sr_e;

  // Strap capture states.
  typedef enum logic [0:0] {CAP_WAIT, CAP_DONE} tsf_cap_e;

endpackage : tsf_pkg

// File: hw/tsf_soft_rst.sv
// Purpose: Timed soft reset sequencer with self-clearing request bit.
// Assumes: Request is a one-cycle pulse taken only while idle.
// Notes:   Busy stays high for a fixed number of cycles, then done pulses.
`timescale 1ns/100ps
module tsf_soft_rst (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  tsf_pkg::tsf_sr_e state_q; // Sequencer state.
  tsf_pkg::tsf_sr_e state_d; // Next sequencer state.
  logic [tsf_pkg::CNT_W-1:0] cnt_q; // Cycles left in the reset.
  logic [tsf_pkg::CNT_W-1:0] cnt_d; // Next count.
  logic done_q; // Completion pulse register.
  logic done_d; // Next completion pulse.

  // Next-state logic; a fixed count stands in for the reset actions.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    unique case (state_q)
      tsf_pkg::SR_IDLE:
      begin
        if (start)
        begin
          state_d = tsf_pkg::SR_BUSY;
          cnt_d = tsf_pkg::CNT_W'(tsf_pkg::SOFT_RST_CYC - 1);
        end
      end
      tsf_pkg::SR_BUSY:
      begin
        if (cnt_q == '0)
        begin
          // Completion self-clears the request bit.
          state_d = tsf_pkg::SR_IDLE;
          done_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - 1'b1;
        end
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= tsf_pkg::SR_IDLE;
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign busy = (state_q == tsf_pkg::SR_BUSY);
  assign done = done_q;

endmodule : tsf_soft_rst

// File: hw/tsf_status.sv
// Purpose: Status flags of the master status and reset word plus its reset bits.
// Assumes: Event inputs are one-cycle pulses synchronous to clk; rst is the
//          master reset pin, asynchronous and active high.
// Notes:   The host port engine presents word reads and writes to this block.
`timescale 1ns/100ps

module tsf_status (
  input wire logic clk,
  input wire logic rst,
  input wire logic auto_init_enable_pin,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic mon_cmd_valid,
  input wire logic mon_msg_done,
  input wire logic mon_pkt_start,
  input wire logic mon_pkt_done,
  input wire logic term_cmd_valid,
  input wire logic term_msg_done,
  input wire logic term_shutdown_cmd,
  input wire logic term_shutdown_bus,
  input wire logic term_override_cmd,
  input wire logic ee_checksum_fail,
  input wire logic ee_ram_mismatch,
  output logic [15:0] status_word,
  output logic ready,
  output logic bit_word_shut_bus,
  output logic hwp_checksum_set,
  output logic hwp_ram_init_set,
  output logic terminal_soft_reset_busy,
  output logic monitor_soft_reset_busy
);

  // ---------------------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------------------
  tsf_pkg::tsf_cap_e cap_q; // Has the strap been caught since reset.
  tsf_pkg::tsf_cap_e cap_d; // Next capture state.
  logic auto_init_enable_pin_q; // Captured auto-init strap.
  logic auto_init_enable_pin_d; // Next captured strap.

  // The strap is taken on the first edge after release, never by the reset.
  always_comb
  begin
    cap_d = cap_q;
    auto_init_enable_pin_d = auto_init_enable_pin_q;
    unique case (cap_q)
      tsf_pkg::CAP_WAIT:
      begin
        cap_d = tsf_pkg::CAP_DONE;
        auto_init_enable_pin_d = auto_init_enable_pin;
      end
      tsf_pkg::CAP_DONE:
      begin
        auto_init_enable_pin_d = auto_init_enable_pin_q;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cap_q <= tsf_pkg::CAP_WAIT;
      auto_init_enable_pin_q <= 1'b0;
    end
    else
    begin
      cap_q <= cap_d;
      auto_init_enable_pin_q <= auto_init_enable_pin_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Soft reset sequencers
  // ---------------------------------------------------------------------------
  logic term_rst_busy; // Terminal soft reset underway.
  logic term_rst_done; // Terminal soft reset finished this cycle.
  logic mon_rst_busy; // Monitor soft reset underway.
  logic mon_rst_done; // Monitor soft reset finished this cycle.
  logic wr_ok; // Host writes land only while access is open.
  logic term_rst_req; // Host asks for a terminal soft reset.
  logic mon_rst_req; // Host asks for a monitor soft reset.
  logic ready_q; // Host access open.
  logic ready_d; // Next host access state.

  // Writes during a soft reset are locked out, as is host access in general.
  assign wr_ok = reg_wr && ready_q;
  assign term_rst_req = wr_ok && reg_wdata[tsf_pkg::BIT_TERM_RST];
  assign mon_rst_req = wr_ok && reg_wdata[tsf_pkg::BIT_MON_RST];

  // Terminal reset: clears terminal state and shutdown.
  tsf_soft_rst u_term_rst (
    .clk(clk),
    .rst(rst),
    .start(term_rst_req),
    .busy(term_rst_busy),
    .done(term_rst_done)
  );

  // Monitor reset: clears monitor state.
  tsf_soft_rst u_mon_rst (
    .clk(clk),
    .rst(rst),
    .start(mon_rst_req),
    .busy(mon_rst_busy),
    .done(mon_rst_done)
  );

  // ---------------------------------------------------------------------------
  // Flags
  // ---------------------------------------------------------------------------
  logic mon_msg_q, mon_msg_d; // Monitor message in progress.
  logic mon_pkt_q, mon_pkt_d; // Monitor packet in progress.
  logic term_msg_q, term_msg_d; // Terminal message in progress.
  logic inh_q, inh_d; // Terminal bus inhibited.
  logic shut_bus_q, shut_bus_d; // Which bus was shut down.
  logic cksum_q, cksum_d; // Checksum error, sticky until master reset.
  logic ram_init_fail_q, ram_init_fail_d; // RAM mismatch, sticky until master reset.
  logic hwp_ck_q, hwp_ck_d; // Pending-register set pulse, checksum.
  logic hwp_ram_q, hwp_ram_d; // Pending-register set pulse, RAM mismatch.
  logic trb_q, trb_d; // Registered terminal reset busy.
  logic mrb_q, mrb_d; // Registered monitor reset busy.
  logic [15:0] stat_q, stat_d; // Readable status word.
  logic term_clr; // Terminal soft reset start clears terminal state.
  logic mon_clr; // Monitor soft reset start clears monitor state.

  assign term_clr = term_rst_req;
  assign mon_clr = mon_rst_req;

  // Flag next values; a set in the same cycle as a clear wins.
  always_comb
  begin
    // Message flags: command sets, completion or soft reset clears.
    mon_msg_d = mon_cmd_valid || (mon_msg_q && !mon_msg_done && !mon_clr);
    mon_pkt_d = mon_pkt_start || (mon_pkt_q && !mon_pkt_done && !mon_clr);
    term_msg_d = term_cmd_valid || (term_msg_q && !term_msg_done && !term_clr);
    // Shutdown holds the flag; override or terminal soft reset ends it.
    inh_d = term_shutdown_cmd || (inh_q && !term_override_cmd && !term_clr);
    // The shut-down bus is remembered for the BIT word.
    shut_bus_d = term_shutdown_cmd ? term_shutdown_bus : shut_bus_q;
    // Errors count only when auto-init was strapped on.
    cksum_d = cksum_q || (ee_checksum_fail && auto_init_enable_pin_q);
    ram_init_fail_d = ram_init_fail_q || (ee_ram_mismatch && auto_init_enable_pin_q);
    hwp_ck_d = ee_checksum_fail && auto_init_enable_pin_q;
    hwp_ram_d = ee_ram_mismatch && auto_init_enable_pin_q;
    trb_d = term_rst_busy || term_rst_req;
    mrb_d = mon_rst_busy || mon_rst_req;
    // Access reopens once both soft resets have finished.
    ready_d = !(trb_d || mrb_d) || ((term_rst_done || !term_rst_busy)
              && (mon_rst_done || !mon_rst_busy) && !term_rst_req && !mon_rst_req);
    // Assemble the word; unused bits stay zero and writes reach flags only through the soft reset bits.
    stat_d = tsf_pkg::STATUS_RST;
    stat_d[tsf_pkg::BIT_READY] = ready_d;
    stat_d[tsf_pkg::BIT_AUTO_INIT_ENABLE_PIN] = auto_init_enable_pin_d;
    stat_d[tsf_pkg::BIT_MON_RST] = mrb_d && !mon_rst_done;
    stat_d[tsf_pkg::BIT_TERM_RST] = trb_d && !term_rst_done;
    stat_d[tsf_pkg::BIT_MON_MSG] = mon_msg_d;
    stat_d[tsf_pkg::BIT_MON_PKT] = mon_pkt_d;
    stat_d[tsf_pkg::BIT_TERM_MSG] = term_msg_d;
    stat_d[tsf_pkg::BIT_TERM_INH] = inh_d;
    stat_d[tsf_pkg::BIT_CKSUM] = cksum_d;
    stat_d[tsf_pkg::BIT_RAM_INIT_FAIL] = ram_init_fail_d;
  end

  // Registers only; master reset clears every flag.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mon_msg_q <= 1'b0;
      mon_pkt_q <= 1'b0;
      term_msg_q <= 1'b0;
      inh_q <= 1'b0;
      shut_bus_q <= 1'b0;
      cksum_q <= 1'b0;
      ram_init_fail_q <= 1'b0;
      hwp_ck_q <= 1'b0;
      hwp_ram_q <= 1'b0;
      ready_q <= 1'b0;
      trb_q <= 1'b0;
      mrb_q <= 1'b0;
      stat_q <= tsf_pkg::STATUS_RST;
    end
    else
    begin
      mon_msg_q <= mon_msg_d;
      mon_pkt_q <= mon_pkt_d;
      term_msg_q <= term_msg_d;
      inh_q <= inh_d;
      shut_bus_q <= shut_bus_d;
      cksum_q <= cksum_d;
      ram_init_fail_q <= ram_init_fail_d;
      hwp_ck_q <= hwp_ck_d;
      hwp_ram_q <= hwp_ram_d;
      ready_q <= ready_d;
      trb_q <= trb_d && !term_rst_done;
      mrb_q <= mrb_d && !mon_rst_done;
      stat_q <= stat_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------------------
  assign status_word = stat_q;
  assign ready = ready_q;
  assign bit_word_shut_bus = shut_bus_q;
  assign hwp_checksum_set = hwp_ck_q;
  assign hwp_ram_init_set = hwp_ram_q;
  assign terminal_soft_reset_busy = trb_q;
  assign monitor_soft_reset_busy = mrb_q;

endmodule : tsf_status

// File: dv/tsf_status_sva.sv
// Purpose: Assertions on the status block ports.
// Assumes: One clock, rst asynchronous and active high.
// Notes: Bound to every status block instance.
`timescale 1ns/100ps
module tsf_status_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic mon_cmd_valid,
  input wire logic mon_pkt_start,
  input wire logic term_cmd_valid,
  input wire logic term_shutdown_cmd,
  input wire logic term_shutdown_bus,
  input wire logic term_override_cmd,
  input wire logic ee_checksum_fail,
  input wire logic ee_ram_mismatch,
  input wire logic [15:0] status_word,
  input wire logic ready,
  input wire logic bit_word_shut_bus,
  input wire logic hwp_checksum_set,
  input wire logic hwp_ram_init_set,
  input wire logic terminal_soft_reset_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Accepted host write that starts a terminal reset.
  sequence rst_req;
    reg_wr && ready && reg_wdata[10];
  endsequence
  // Access locked and terminal flags cleared for the first 8 cycles of the run.
  sequence rst_hold;
    (!ready && status_word[10] && terminal_soft_reset_busy && (status_word[4:2] == 3'h0))[*8];
  endsequence
  // Request bit self-cleared and access restored.
  sequence rst_end;
    ready && !status_word[10] && !terminal_soft_reset_busy;
  endsequence
  chk_soft_rst_seq: assert property (rst_req |=> rst_hold ##[100:140] rst_end)
    else $error("soft reset sequence wrong");
  chk_mon_msg_set: assert property (mon_cmd_valid |=> status_word[7])
    else $error("monitor message flag not set");
  chk_mon_pkt_set: assert property (mon_pkt_start |=> status_word[6])
    else $error("monitor packet flag not set");
  chk_term_msg_set: assert property (term_cmd_valid |=> status_word[4])
    else $error("terminal message flag not set");
  chk_inh_set: assert property (term_shutdown_cmd |=> status_word[2] && bit_word_shut_bus == $past(term_shutdown_bus))
    else $error("inhibit or shut bus wrong");
  chk_inh_clear: assert property (term_override_cmd && !term_shutdown_cmd |=> !status_word[2])
    else $error("override left inhibit set");
  chk_cksum_pend: assert property (ee_checksum_fail && status_word[13] |=> hwp_checksum_set && status_word[1])
    else $error("checksum error not flagged");
  chk_ram_pend: assert property (ee_ram_mismatch && status_word[13] |=> hwp_ram_init_set && status_word[0])
    else $error("ram mismatch not flagged");
  chk_strap_gate: assert property (!status_word[13] |-> status_word[1:0] == 2'h0 && !hwp_checksum_set && !hwp_ram_init_set)
    else $error("error flag with strap low");
  chk_unused_zero: assert property ((status_word & 16'h4b28) == 16'h0000)
    else $error("unused status bit set");
endmodule : tsf_status_sva
bind tsf_status tsf_status_sva tsf_status_sva_i (
  .clk, .rst, .reg_wr, .reg_wdata, .mon_cmd_valid, .mon_pkt_start, .term_cmd_valid,
  .term_shutdown_cmd, .term_shutdown_bus, .term_override_cmd, .ee_checksum_fail,
  .ee_ram_mismatch, .status_word, .ready, .bit_word_shut_bus, .hwp_checksum_set,
  .hwp_ram_init_set, .terminal_soft_reset_busy
);

// File: dv/tsf_host_model.sv
// Purpose: Host model issuing word writes.
// Assumes: A write is taken at a rising edge with ready high.
// Notes: Idle data shows the inverse of the last word.
`timescale 1ns/100ps
module tsf_host_model (
  input wire logic clk,
  input wire logic ready,
  output logic reg_wr,
  output logic [15:0] reg_wdata
);
  // Quiet bus at time zero.
  initial
  begin
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  // Writes wait for ready, since locked-out writes are lost.
  task automatic write(input logic [15:0] data);
    while (ready !== 1'b1) @(negedge clk);
    reg_wr = 1'b1;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask : write
endmodule : tsf_host_model

// File: dv/test_tsf_status.sv
// Purpose: Self-checking bench for the status block.
// Assumes: Inputs change at the falling edge.
// Notes: A row table covers plain events; resets are hand tested.
`timescale 1ns/100ps
module test_tsf_status;
  typedef struct {logic [10:0] ev; logic [15:0] sw;} tsf_row_s; // Events and expected word.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap = 1'b1;
  logic [10:0] ev = 11'h000; // Bus id, shutdown, override, errors, then message events.
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [15:0] status_word;
  logic ready, shut_bus, hwp_ck, hwp_ram, t_busy, m_busy;
  int failures = 0;
  int compares = 0;
  tsf_row_s rows [11] = '{
    '{11'h020, 16'ha080}, '{11'h008, 16'ha0c0}, '{11'h002, 16'ha0d0}, '{11'h010, 16'ha050},
    '{11'h004, 16'ha010}, '{11'h001, 16'ha000}, '{11'h600, 16'ha004}, '{11'h100, 16'ha000},
    '{11'h200, 16'ha004}, '{11'h080, 16'ha006}, '{11'h040, 16'ha007}};
  tsf_status tsf_status_i (.clk(clk), .rst(rst), .auto_init_enable_pin(strap),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .term_shutdown_bus(ev[10]),
    .term_shutdown_cmd(ev[9]), .term_override_cmd(ev[8]), .ee_checksum_fail(ev[7]),
    .ee_ram_mismatch(ev[6]), .mon_cmd_valid(ev[5]), .mon_msg_done(ev[4]),
    .mon_pkt_start(ev[3]), .mon_pkt_done(ev[2]), .term_cmd_valid(ev[1]),
    .term_msg_done(ev[0]), .status_word(status_word), .ready(ready),
    .bit_word_shut_bus(shut_bus), .hwp_checksum_set(hwp_ck), .hwp_ram_init_set(hwp_ram),
    .terminal_soft_reset_busy(t_busy), .monitor_soft_reset_busy(m_busy));
  tsf_host_model host_i (.clk(clk), .ready(ready), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
  // Free-running 125 MHz clock.
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Compare and report a mismatch at once.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Verdict and end of run.
  task automatic end_sim;
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Main sequence: table, then resets and lockout.
  initial
  begin
    repeat (3) @(negedge clk);
    check(status_word, 16'h0000);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(status_word, 16'ha000);
    foreach (rows[i])
    begin
      ev = rows[i].ev;
      @(negedge clk);
      ev = 11'h000;
      check(status_word, rows[i].sw);
      check({14'h0, hwp_ck, hwp_ram}, {14'h0, rows[i].ev[7:6]});
      if (rows[i].ev[9]) check({15'h0, shut_bus}, {15'h0, rows[i].ev[10]});
    end
    host_i.write(16'hebff);
    check(status_word, 16'ha007);
    for (int k = 0; k < 2; k++)
    begin
      ev = (k == 0) ? 11'h202 : 11'h028;
      @(negedge clk);
      ev = 11'h000;
      host_i.write((k == 0) ? 16'h0400 : 16'h1000);
      check(status_word, (k == 0) ? 16'h2403 : 16'h3003);
      check({15'h0, ready}, 16'h0000);
      check({15'h0, (k == 0) ? t_busy : m_busy}, 16'h0001);
      for (int n = 0; n < 300 && ready !== 1'b1; n++) @(negedge clk);
      check(status_word, 16'ha003);
    end
    // Errors must be ignored once the strap is low.
    strap = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(status_word, 16'h8000);
    ev = 11'h0c0;
    @(negedge clk);
    ev = 11'h000;
    check(status_word | {14'h0, hwp_ck, hwp_ram}, 16'h8000);
    end_sim();
  end
  // Watchdog against a hang.
  initial
  begin
    #20000;
    failures++;
    end_sim();
  end
endmodule : test_tsf_status
